// ===== mbus_slave_end.sv
// Slave end: receive FIFO, frame checker, register access sequencer and answer sender.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_reg_type;
  fifo_reg_type cur_ff;
  fifo_reg_type nxt_ff;
  logic [W-1:0] mem [DEPTH];

  // Full when the pointers differ only in the wrap bit, empty when equal.
  assign in_ready = !((cur_ff.wr[AW] != cur_ff.rd[AW]) && (cur_ff.wr[AW-1:0] == cur_ff.rd[AW-1:0]));
  assign out_valid = (cur_ff.wr != cur_ff.rd);
  assign out_data = mem[cur_ff.rd[AW-1:0]];

  // Pointer advance on each accepted push and pop.
  always_comb
  begin
    nxt_ff = cur_ff;
    if (in_valid && in_ready)
      nxt_ff.wr = cur_ff.wr + 1'b1;
    if (out_valid && out_ready)
      nxt_ff.rd = cur_ff.rd + 1'b1;
  end

  // Pointer registers and the storage write.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cur_ff <= '0;
    else
      cur_ff <= nxt_ff;
    if (in_valid && in_ready)
      mem[cur_ff.wr[AW-1:0]] <= in_data;
  end
endmodule

// Behaviour
// - Answer only frames carrying our own address.
// - Drive line only while answering a query.
// - Support read 03H and write 10H.
// - Checksum starts at all ones.
// - Xor each byte into checksum low byte.
// - Shift right, xor polynomial on carry out.
// - Eight shift steps per byte.
// - Append checksum; mismatching received checksum is error.
// - Words and fields travel high byte first.
// - Read request: address, code, start, count, checksum.
// - Read answer: address, code, byte count, data.
// - Write request adds byte count and data words.
// - Write answer echoes start and count.
// - Exception: address, code with top bit, error.
// - Unsupported function code answers error 81.
// - Address outside range answers error 82.
// - Value outside range answers error 83.
// - Zero write of two at 000CH clears energy.
// - Checksum low byte sent first.
// - Failed frame gets no answer at all.
// - Characters carry start, eight data, parity, stop.
module mbus_slave_end #(
  parameter int GAP_CYC = mbus_pkg::GAP_CYCLES,
  parameter int CHAR_CYC = mbus_pkg::CHAR_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  mbus_link_if.slave                       link,
  input  wire logic [mbus_pkg::BYTE_W-1:0] slave_addr,
  output logic [mbus_pkg::WORD_W-1:0]      reg_addr,
  output logic                             reg_write,
  output logic [mbus_pkg::WORD_W-1:0]      reg_wdata,
  output logic                             reg_we,
  input  wire logic [mbus_pkg::WORD_W-1:0] reg_rdata,
  input  wire logic                        reg_addr_ok,
  input  wire logic                        reg_val_ok,
  output logic                             energy_clear
);
  import mbus_pkg::*;

  typedef struct packed {
    dev_state_type state;
    logic [15:0]   gap;
    logic [15:0]   pace;
    logic [6:0]    len;
    logic          ovf;
    logic [15:0]   crc;
    logic [6:0]    idx;
    logic [7:0]    err;
    logic          exc;
  } dev_reg_type;
  dev_reg_type cur_ff;
  dev_reg_type nxt_ff;
  logic [7:0]  rx_mem [RX_DEPTH];

  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        fifo_in_ready;
  logic        rx_phase;
  logic [7:0]  fc;
  logic [15:0] start;
  logic [15:0] count;
  logic [7:0]  bcnt;
  logic        is_wr;
  logic [6:0]  wofs;
  logic [6:0]  tx_len;
  logic [6:0]  rd_pos;
  logic [7:0]  tx_byte;
  logic        clr_data_zero;

  // Bytes enter only while listening; the FIFO stalls the host when full.
  assign rx_phase = (cur_ff.state == D_RX);
  assign link.req_ready = fifo_in_ready && rx_phase;

  byte_fifo #(.W(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (link.req_valid && rx_phase),
    .in_ready  (fifo_in_ready),
    .in_data   (link.req_data),
    .out_valid (fifo_out_valid),
    .out_ready (rx_phase),
    .out_data  (fifo_out_data)
  );

  // Request fields, all high byte first.
  assign fc = rx_mem[OFS_FC];
  assign start = {rx_mem[OFS_START], rx_mem[OFS_START+1]};
  assign count = {rx_mem[OFS_COUNT], rx_mem[OFS_COUNT+1]};
  assign bcnt = rx_mem[OFS_BCNT];
  assign is_wr = (fc == FC_WRITE);
  assign wofs = 7'(OFS_WDATA) + {cur_ff.idx[5:0], 1'b0};
  assign reg_wdata = {rx_mem[wofs[5:0]], rx_mem[6'(wofs + 7'h01)]};
  assign reg_write = is_wr;
  assign clr_data_zero = ({rx_mem[OFS_WDATA], rx_mem[OFS_WDATA+1], rx_mem[OFS_WDATA+2],
                           rx_mem[OFS_WDATA+3]} == 32'h0000_0000);
  assign rd_pos = cur_ff.idx - READ_HDR_LEN;

  // Register address: walk from the start during checks, then follow the answer bytes.
  always_comb
  begin
    if (cur_ff.state == D_TX)
      reg_addr = start + {10'h000, rd_pos[6:1]};
    else
      reg_addr = start + {9'h000, cur_ff.idx};
  end

  // Answer body length and the byte at the current position.
  always_comb
  begin
    if (cur_ff.exc)
      tx_len = EXC_BODY_LEN;
    else if (is_wr)
      tx_len = WRITE_ACK_LEN;
    else
      tx_len = READ_HDR_LEN + {count[5:0], 1'b0};
    if (cur_ff.idx == tx_len)
      tx_byte = cur_ff.crc[7:0];
    else if (cur_ff.idx == tx_len + 7'h01)
      tx_byte = cur_ff.crc[15:8];
    else if (cur_ff.idx == 7'h00)
      tx_byte = slave_addr;
    else if (cur_ff.idx == 7'h01)
      tx_byte = cur_ff.exc ? (fc | EXC_FLAG) : fc;
    else if (cur_ff.exc)
      tx_byte = cur_ff.err;
    else if (is_wr)
      tx_byte = rx_mem[cur_ff.idx[5:0]];
    else if (cur_ff.idx == 7'h02)
      tx_byte = {count[6:0], 1'b0};
    else
      tx_byte = rd_pos[0] ? reg_rdata[7:0] : reg_rdata[15:8];
  end

  assign link.rsp_data = tx_byte;
  assign link.rsp_valid = (cur_ff.state == D_TX) && (cur_ff.pace == 16'h0000);
  assign link.rsp_drive = (cur_ff.state == D_TX);

  // Sequencer: gather a frame, judge it, check and apply registers, then answer.
  always_comb
  begin
    nxt_ff = cur_ff;
    reg_we = 1'b0;
    energy_clear = 1'b0;
    case (cur_ff.state)
      D_RX:
      begin
        if (link.req_valid && link.req_ready)
          nxt_ff.gap = 16'h0000;
        else if (cur_ff.gap != 16'(GAP_CYC - 1))
          nxt_ff.gap = cur_ff.gap + 16'h0001;
        if (fifo_out_valid)
        begin
          if (cur_ff.len == 7'(RX_DEPTH))
            nxt_ff.ovf = 1'b1;
          else
            nxt_ff.len = cur_ff.len + 7'h01;
          nxt_ff.crc = crc_byte(cur_ff.crc, fifo_out_data);
        end
        else if ((cur_ff.gap == 16'(GAP_CYC - 1)) && (cur_ff.len != 7'h00))
        begin
          nxt_ff.len = 7'h00;
          nxt_ff.ovf = 1'b0;
          nxt_ff.crc = CRC_INIT;
          nxt_ff.idx = 7'h00;
          nxt_ff.exc = 1'b0;
          // A whole frame with its checksum leaves a zero residue.
          if (!cur_ff.ovf && (cur_ff.crc == 16'h0000) && (cur_ff.len >= MIN_FRAME_LEN)
              && (rx_mem[OFS_ADDR] == slave_addr))
          begin
            if ((fc != FC_READ) && !is_wr)
            begin
              nxt_ff.exc = 1'b1;
              nxt_ff.err = ERR_FUNC;
              nxt_ff.state = D_TX;
            end
            else if (is_wr ? ((cur_ff.len != WRITE_OVERHEAD + 7'(bcnt))
                              || ({8'h00, bcnt} != {count[14:0], 1'b0}))
                           : (cur_ff.len != READ_REQ_LEN))
              nxt_ff.state = D_RX;
            else if ((count == 16'h0000) || (count > MAX_REGS)
                     || (({1'b0, start} + {1'b0, count}) > 17'h10000))
            begin
              nxt_ff.exc = 1'b1;
              nxt_ff.err = ERR_ADDR;
              nxt_ff.state = D_TX;
            end
            else
              nxt_ff.state = D_CHECK;
          end
        end
      end
      D_CHECK:
      begin
        if (!reg_addr_ok)
        begin
          nxt_ff.exc = 1'b1;
          nxt_ff.err = ERR_ADDR;
          nxt_ff.idx = 7'h00;
          nxt_ff.state = D_TX;
        end
        else if (is_wr && !reg_val_ok)
        begin
          nxt_ff.exc = 1'b1;
          nxt_ff.err = ERR_VALUE;
          nxt_ff.idx = 7'h00;
          nxt_ff.state = D_TX;
        end
        else if ({9'h000, cur_ff.idx} == count - 16'h0001)
        begin
          nxt_ff.idx = 7'h00;
          nxt_ff.state = is_wr ? D_EXEC : D_TX;
        end
        else
          nxt_ff.idx = cur_ff.idx + 7'h01;
      end
      D_EXEC:
      begin
        reg_we = 1'b1;
        if ({9'h000, cur_ff.idx} == count - 16'h0001)
        begin
          energy_clear = (start == ENERGY_CLR_START) && (count == ENERGY_CLR_COUNT)
                         && clr_data_zero;
          nxt_ff.idx = 7'h00;
          nxt_ff.state = D_TX;
        end
        else
          nxt_ff.idx = cur_ff.idx + 7'h01;
      end
      D_TX:
      begin
        if (cur_ff.pace != 16'h0000)
          nxt_ff.pace = cur_ff.pace - 16'h0001;
        else if (link.rsp_ready)
        begin
          nxt_ff.pace = 16'(CHAR_CYC - 1);
          if (cur_ff.idx < tx_len)
            nxt_ff.crc = crc_byte(cur_ff.crc, tx_byte);
          if (cur_ff.idx == tx_len + 7'h01)
          begin
            nxt_ff.state = D_RX;
            nxt_ff.idx = 7'h00;
            nxt_ff.crc = CRC_INIT;
            nxt_ff.pace = 16'h0000;
            nxt_ff.gap = 16'h0000;
            nxt_ff.exc = 1'b0;
          end
          else
            nxt_ff.idx = cur_ff.idx + 7'h01;
        end
      end
      default:
        nxt_ff.state = D_RX;
    endcase
  end

  // State register and capture of frame bytes as they leave the FIFO.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.state <= D_RX;
      cur_ff.crc <= CRC_INIT;
    end
    else
      cur_ff <= nxt_ff;
    if (rx_phase && fifo_out_valid && (cur_ff.len != 7'(RX_DEPTH)))
      rx_mem[cur_ff.len[5:0]] <= fifo_out_data;
  end
endmodule
`default_nettype wire

// ===== mbus_pkg.sv
// Shared constants, frame layout and the checksum step of the serial register protocol.
`default_nettype none
package mbus_pkg;
  localparam int CLK_MHZ = 10;
  // One character at 9600 bit/s with 11 bits, rounded up to whole microseconds.
  localparam int CHAR_TIME_US = 1146;
  localparam int CHAR_CYCLES = CHAR_TIME_US * CLK_MHZ;
  // Idle gap of three and a half characters that closes a frame.
  localparam int GAP_TIME_US = 4011;
  localparam int GAP_CYCLES = GAP_TIME_US * CLK_MHZ;
  // Longest wait of the host for the end of an answer.
  localparam int TIMEOUT_US = 100000;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int RX_DEPTH = 64;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int CRC_STEPS = 8;
  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] ERR_FUNC = 8'h81;
  localparam logic [7:0] ERR_ADDR = 8'h82;
  localparam logic [7:0] ERR_VALUE = 8'h83;
  localparam logic [15:0] ENERGY_CLR_START = 16'h000C;
  localparam logic [15:0] ENERGY_CLR_COUNT = 16'h0002;
  localparam logic [15:0] MAX_REGS = 16'h001B;
  // Byte positions inside a request frame.
  localparam int OFS_ADDR = 0;
  localparam int OFS_FC = 1;
  localparam int OFS_START = 2;
  localparam int OFS_COUNT = 4;
  localparam int OFS_BCNT = 6;
  localparam int OFS_WDATA = 7;
  localparam logic [6:0] READ_REQ_LEN = 7'h08;
  localparam logic [6:0] WRITE_OVERHEAD = 7'h09;
  localparam logic [6:0] MIN_FRAME_LEN = 7'h04;
  localparam logic [6:0] EXC_BODY_LEN = 7'h03;
  localparam logic [6:0] WRITE_ACK_LEN = 7'h06;
  localparam logic [6:0] READ_HDR_LEN = 7'h03;

  typedef enum logic [1:0] {D_RX, D_CHECK, D_EXEC, D_TX} dev_state_type;
  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RECV, H_GAP} host_state_type;

  // Folds one byte into the checksum: xor into the low byte, then eight shift steps.
  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < CRC_STEPS; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction
endpackage
`default_nettype wire

// ===== mbus_link_if.sv
// Byte link between the host end and the slave end of the half-duplex line.
`timescale 1ns/1ps
`default_nettype none
interface mbus_link_if;
  logic [7:0] req_data;
  logic       req_valid;
  logic       req_ready;
  logic [7:0] rsp_data;
  logic       rsp_valid;
  logic       rsp_ready;
  logic       rsp_drive;
  modport slave (input req_data, input req_valid, output req_ready,
                 output rsp_data, output rsp_valid, output rsp_drive, input rsp_ready);
  modport master (output req_data, output req_valid, input req_ready,
                  input rsp_data, input rsp_valid, input rsp_drive, output rsp_ready);
endinterface
`default_nettype wire

// ===== mbus_host_end.sv
// Host end: builds read and write requests, collects and checks the answers.
`timescale 1ns/1ps
`default_nettype none
module mbus_host_end #(
  parameter int GAP_CYC = mbus_pkg::GAP_CYCLES,
  parameter int TMO_CYC = mbus_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  mbus_link_if.master                      link,
  input  wire logic                        cmd_valid,
  output logic                             cmd_ready,
  input  wire logic                        cmd_write,
  input  wire logic [mbus_pkg::BYTE_W-1:0] cmd_slave,
  input  wire logic [mbus_pkg::WORD_W-1:0] cmd_start,
  input  wire logic [mbus_pkg::WORD_W-1:0] cmd_count,
  output logic [6:0]                       wr_index,
  input  wire logic [mbus_pkg::WORD_W-1:0] wr_word,
  output logic                             rd_valid,
  output logic [6:0]                       rd_index,
  output logic [mbus_pkg::WORD_W-1:0]      rd_word,
  output logic                             done,
  output logic [1:0]                       done_status,
  output logic [mbus_pkg::BYTE_W-1:0]      done_code
);
  import mbus_pkg::*;

  typedef struct packed {
    host_state_type state;
    logic           wr;
    logic [7:0]     slave;
    logic [15:0]    start;
    logic [15:0]    count;
    logic [7:0]     idx;
    logic [15:0]    crc;
    logic [7:0]     exp_len;
    logic [7:0]     hold;
    logic [23:0]    tmo;
    logic           rd_valid;
    logic [6:0]     rd_index;
    logic [15:0]    rd_word;
    logic           done;
    logic [1:0]     status;
    logic [7:0]     code;
  } host_reg_type;
  host_reg_type cur_ff;
  host_reg_type nxt_ff;
  logic [7:0] req_len;
  logic [7:0] req_byte;
  logic [7:0] dpos;
  logic [15:0] crc_next;

  assign cmd_ready = (cur_ff.state == H_IDLE);
  assign rd_valid = cur_ff.rd_valid;
  assign rd_index = cur_ff.rd_index;
  assign rd_word = cur_ff.rd_word;
  assign done = cur_ff.done;
  assign done_status = cur_ff.status;
  assign done_code = cur_ff.code;
  assign dpos = cur_ff.idx - 8'(OFS_WDATA);
  assign wr_index = dpos[7:1];
  assign crc_next = crc_byte(cur_ff.crc, link.rsp_data);

  // Request body length and the byte at the current position, fields high byte first.
  always_comb
  begin
    req_len = cur_ff.wr ? (8'(OFS_WDATA) + {cur_ff.count[6:0], 1'b0}) : 8'(OFS_BCNT);
    case (cur_ff.idx)
      8'h00: req_byte = cur_ff.slave;
      8'h01: req_byte = cur_ff.wr ? FC_WRITE : FC_READ;
      8'h02: req_byte = cur_ff.start[15:8];
      8'h03: req_byte = cur_ff.start[7:0];
      8'h04: req_byte = cur_ff.count[15:8];
      8'h05: req_byte = cur_ff.count[7:0];
      8'h06: req_byte = {cur_ff.count[6:0], 1'b0};
      default: req_byte = dpos[0] ? wr_word[7:0] : wr_word[15:8];
    endcase
    if (cur_ff.idx == req_len)
      req_byte = cur_ff.crc[7:0];
    else if (cur_ff.idx == req_len + 8'h01)
      req_byte = cur_ff.crc[15:8];
  end

  assign link.req_data = req_byte;
  assign link.req_valid = (cur_ff.state == H_SEND);
  assign link.rsp_ready = (cur_ff.state == H_RECV);

  // Sequencer: send the request, take the answer, then keep the line quiet for a gap.
  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.rd_valid = 1'b0;
    nxt_ff.done = 1'b0;
    case (cur_ff.state)
      H_IDLE:
      begin
        if (cmd_valid)
        begin
          nxt_ff.state = H_SEND;
          nxt_ff.wr = cmd_write;
          nxt_ff.slave = cmd_slave;
          nxt_ff.start = cmd_start;
          nxt_ff.count = cmd_count;
          nxt_ff.idx = 8'h00;
          nxt_ff.crc = CRC_INIT;
        end
      end
      H_SEND:
      begin
        if (link.req_ready)
        begin
          if (cur_ff.idx < req_len)
            nxt_ff.crc = crc_byte(cur_ff.crc, req_byte);
          nxt_ff.idx = cur_ff.idx + 8'h01;
          if (cur_ff.idx == req_len + 8'h01)
          begin
            nxt_ff.state = H_RECV;
            nxt_ff.idx = 8'h00;
            nxt_ff.crc = CRC_INIT;
            nxt_ff.tmo = 24'h000000;
            nxt_ff.exp_len = cur_ff.wr ? 8'h08 : (8'h05 + {cur_ff.count[6:0], 1'b0});
          end
        end
      end
      H_RECV:
      begin
        nxt_ff.tmo = cur_ff.tmo + 24'h000001;
        if (link.rsp_valid)
        begin
          nxt_ff.crc = crc_next;
          nxt_ff.idx = cur_ff.idx + 8'h01;
          if ((cur_ff.idx == 8'h01) && link.rsp_data[7])
            nxt_ff.exp_len = 8'h05;
          if ((cur_ff.idx == 8'h02) && (cur_ff.exp_len == 8'h05))
            nxt_ff.code = link.rsp_data;
          if (!cur_ff.wr && (cur_ff.exp_len != 8'h05) && (cur_ff.idx >= 8'h03)
              && (cur_ff.idx < cur_ff.exp_len - 8'h02))
          begin
            if (cur_ff.idx[0])
              nxt_ff.hold = link.rsp_data;
            else
            begin
              nxt_ff.rd_valid = 1'b1;
              nxt_ff.rd_word = {cur_ff.hold, link.rsp_data};
              nxt_ff.rd_index = 7'((cur_ff.idx - 8'h04) >> 1);
            end
          end
          if (cur_ff.idx == cur_ff.exp_len - 8'h01)
          begin
            nxt_ff.done = 1'b1;
            nxt_ff.state = H_GAP;
            nxt_ff.tmo = 24'h000000;
            if (crc_next != 16'h0000)
              nxt_ff.status = 2'h2;
            else
              nxt_ff.status = (cur_ff.exp_len == 8'h05) ? 2'h1 : 2'h0;
          end
        end
        else if (cur_ff.tmo == 24'(TMO_CYC - 1))
        begin
          nxt_ff.done = 1'b1;
          nxt_ff.status = 2'h3;
          nxt_ff.state = H_GAP;
          nxt_ff.tmo = 24'h000000;
        end
      end
      H_GAP:
      begin
        nxt_ff.tmo = cur_ff.tmo + 24'h000001;
        if (cur_ff.tmo == 24'(GAP_CYC - 1))
          nxt_ff.state = H_IDLE;
      end
      default:
        nxt_ff.state = H_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.state <= H_IDLE;
      cur_ff.crc <= CRC_INIT;
    end
    else
      cur_ff <= nxt_ff;
  end
endmodule
`default_nettype wire

// ===== mbus_link_checker.sv
// Checker of the byte link between the host end and the slave end.
`timescale 1ns/1ps
`default_nettype none
module mbus_link_checker #(
  parameter int GAP_CYC = 40
) (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic [7:0] req_data,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_valid,
  input wire logic       rsp_ready,
  input wire logic       rsp_drive
);
  logic [15:0] idle_ff;
  logic [7:0]  addr_ff;
  logic [7:0]  fc_ff;
  logic [6:0]  cnt_ff;
  logic        first_ff;
  logic        take_q;
  logic        take_s;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Byte handshakes on the two directions.
  assign take_q = req_valid && req_ready;
  assign take_s = rsp_valid && rsp_ready;
  // Tracks idle time, the first byte of a frame and the answer byte count.
  always_ff @(posedge ref_clk)
  begin
    idle_ff  <= (!rst_n || take_q) ? 16'h0000 : idle_ff + {15'h0000, ~&idle_ff};
    first_ff <= !rst_n || (!take_q && (first_ff || idle_ff >= GAP_CYC - 1));
    addr_ff  <= (take_q && first_ff) ? req_data : addr_ff;
    cnt_ff   <= (!rst_n || !rsp_drive) ? 7'h00 : cnt_ff + {6'h00, take_s};
    fc_ff    <= (take_s && cnt_ff == 7'h01) ? rsp_data : fc_ff;
  end
  sequence stalled_answer;
    rsp_valid && !rsp_ready;
  endsequence
  sequence answer_end;
    $fell(rsp_drive);
  endsequence
  only_answer_a: assert property (rsp_valid |-> rsp_drive)
    else $error("answer byte without line");
  no_listen_a: assert property (rsp_drive |-> !req_ready && !req_valid)
    else $error("both directions active");
  rsp_hold_a: assert property (stalled_answer |=> rsp_valid && $stable(rsp_data))
    else $error("answer byte dropped");
  req_hold_a: assert property (req_valid && !req_ready |=> req_valid && $stable(req_data))
    else $error("request byte dropped");
  gap_first_a: assert property ($rose(rsp_drive) |-> idle_ff >= GAP_CYC - 1)
    else $error("answer before frame gap");
  own_addr_a: assert property (rsp_valid && cnt_ff == 7'h00 |-> rsp_data == addr_ff)
    else $error("answer address wrong");
  exc_code_a: assert property (rsp_valid && cnt_ff == 7'h02 && fc_ff[7]
    |-> rsp_data inside {8'h81, 8'h82, 8'h83}) else $error("bad error code");
  exc_len_a: assert property (answer_end and fc_ff[7] |-> cnt_ff == 7'h05)
    else $error("exception length wrong");
  ack_len_a: assert property (answer_end and fc_ff == 8'h10 |-> cnt_ff == 7'h08)
    else $error("write ack length wrong");
endmodule
`default_nettype wire

// ===== tb_modbus_rtu_slave_frame_handler.sv
// Self-checking bench joining the host end and the slave end over the byte link.
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_rtu_slave_frame_handler;
  logic        ref_clk, rst_n, cmd_valid, cmd_ready, cmd_write, reg_write, reg_we;
  logic        energy_clear, rd_valid, done, reg_addr_ok, reg_val_ok;
  logic [7:0]  cmd_slave, done_code, slave_addr;
  logic [15:0] cmd_start, cmd_count, wr_word, rd_word, reg_addr, reg_wdata, reg_rdata;
  logic [6:0]  wr_index, rd_index;
  logic [1:0]  done_status;
  logic [15:0] wdat [4];
  logic [7:0]  rq [$], sq [$];
  logic [15:0] dq [$];
  logic [31:0] wq [$];
  int          mismatches, samples_checked, clr_cnt;
  mbus_link_if link ();
  mbus_slave_end #(.GAP_CYC(40), .CHAR_CYC(4)) mbus_slave_end_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link), .slave_addr(slave_addr), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
    .reg_addr_ok(reg_addr_ok), .reg_val_ok(reg_val_ok), .energy_clear(energy_clear));
  mbus_host_end #(.GAP_CYC(48), .TMO_CYC(2000)) mbus_host_end_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_slave(cmd_slave), .cmd_start(cmd_start),
    .cmd_count(cmd_count), .wr_index(wr_index), .wr_word(wr_word), .rd_valid(rd_valid),
    .rd_index(rd_index), .rd_word(rd_word), .done(done), .done_status(done_status),
    .done_code(done_code));
  mbus_link_checker #(.GAP_CYC(40)) mbus_link_checker_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .req_data(link.req_data), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .rsp_data(link.rsp_data), .rsp_valid(link.rsp_valid),
    .rsp_ready(link.rsp_ready), .rsp_drive(link.rsp_drive));
  // Register side: data follows the address, 0000H-002FH and 0100H-01FFH exist, all ones is refused.
  assign reg_rdata   = reg_addr ^ 16'h5A00;
  assign reg_addr_ok = (reg_addr < 16'h0030) || (reg_addr[15:8] == 8'h01);
  assign reg_val_ok  = reg_wdata != 16'hFFFF;
  assign wr_word     = wdat[wr_index[1:0]];
  // Makes the 10 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Records link bytes, read words and register writes where all is settled.
  always @(negedge ref_clk)
  begin
    if (link.req_valid === 1'b1 && link.req_ready === 1'b1) rq.push_back(link.req_data);
    if (link.rsp_valid === 1'b1 && link.rsp_ready === 1'b1) sq.push_back(link.rsp_data);
    if (rd_valid === 1'b1) dq.push_back(rd_word);
    if (reg_we === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (energy_clear === 1'b1) clr_cnt++;
  end
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_seq(input string what, input logic [7:0] exp [$], input logic [7:0] got [$]);
    chk(what, exp.size(), got.size());
    foreach (exp[i]) chk(what, exp[i], got[i]);
  endtask
  // Issues one command through the host end and waits for its completion.
  task automatic run(input logic wr, input logic [7:0] sl, input logic [15:0] st,
                     input logic [15:0] cn, input logic [1:0] est, input logic [7:0] ecode);
    int n;
    rq.delete();
    sq.delete();
    dq.delete();
    wq.delete();
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("ready", 1'b1, cmd_ready);
    {cmd_write, cmd_slave, cmd_start, cmd_count} = {wr, sl, st, cn};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("done", 1'b1, done);
    chk("status", est, done_status);
    if (est == 2'd1) chk("error code", ecode, done_code);
    @(posedge ref_clk);
  endtask
  // Cuts a hung run short.
  initial
  begin
    #4000000;
    mismatches++;
    end_sim;
  end
  // Main sequence of commands.
  initial
  begin
    {rst_n, cmd_valid, cmd_write, cmd_slave, cmd_start, cmd_count} = '0;
    slave_addr = 8'h01;
    wdat = '{16'h0104, 16'h01F4, 16'h0000, 16'h0000};
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    run(1'b0, 8'h01, 16'h0100, 16'h0003, 2'd0, 8'h00);
    chk("read flag", 1'b0, reg_write);
    chk_seq("read req", '{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h03, 8'h04, 8'h37}, rq);
    chk("byte count", 8'h06, sq[2]);
    chk("data high", 8'h5B, sq[3]);
    chk("words", 3, dq.size());
    for (int i = 0; i < 3; i++) chk("read word", 16'h5B00 + i, dq[i]);
    run(1'b1, 8'h01, 16'h0020, 16'h0002, 2'd0, 8'h00);
    chk("write flag", 1'b1, reg_write);
    chk_seq("write req", '{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h01, 8'h04,
            8'h01, 8'hF4, 8'hB1, 8'h9D}, rq);
    chk_seq("write ack", '{8'h01, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h40, 8'h02}, sq);
    chk("write 0", 32'h0020_0104, wq[0]);
    chk("write 1", 32'h0021_01F4, wq[1]);
    wdat[1] = 16'h0000;
    wdat[0] = 16'h0000;
    run(1'b1, 8'h01, 16'h000C, 16'h0002, 2'd0, 8'h00);
    chk_seq("clear ack", '{8'h01, 8'h10, 8'h00, 8'h0C, 8'h00, 8'h02, 8'h81, 8'hCB}, sq);
    chk("clears", 1, clr_cnt);
    run(1'b0, 8'h02, 16'h0100, 16'h0001, 2'd3, 8'h00);
    chk("silence", 0, sq.size());
    run(1'b0, 8'h01, 16'h002F, 16'h0002, 2'd1, 8'h82);
    chk("exc len", 5, sq.size());
    chk("exc fc", 8'h83, sq[1]);
    run(1'b0, 8'h01, 16'h0000, 16'h0000, 2'd1, 8'h82);
    wdat[0] = 16'hFFFF;
    run(1'b1, 8'h01, 16'h0020, 16'h0001, 2'd1, 8'h83);
    chk("no write", 0, wq.size());
    end_sim;
  end
endmodule
`default_nettype wire
